// [design/sar_adc_conversion_control.sv]
// Converter end: approximation register and completion flag of a 12-bit converter.
// Assumes the comparator bit and the start request are synchronous to core_clk.
// Assumes the controller end is joined through the interface's controller modport.
// Behaviour
// R1: Result is complemented binary, MSB on top.
// R2: Result valid only after done falls.
// R3: Start request resets register synchronously.
// R4: Done high while converting, low when finished.
// R5: Controller may truncate sequence, saving two intervals; the bit-two tap here ends it after ten intervals, saving three.
// R6: Truncating controller ORs bit two with done.
// R7: Done tied to start gives continuous conversion.
// R8: Twelve bits give 4096 distinct codes.
// R9: Start low loads MSB low, rest high.
// R10: Each edge resolves trial bit, next bit low.
// R11: Result and done hold until next start.
// R12: Full conversion takes thirteen clock intervals.
// R13: Comparator bit sampled on resolving edge.
`timescale 1ns/100ps
module sar_adc_conversion_control (
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          comparator_bit,
    output logic [3:0]         trial_index,
    sar_adc_if.converter       pins
);
    import sar_adc_pkg::*;

    // Conversion phases, Gray coded along idle, load, run and done.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b11,
        ST_DONE = 2'b10
    } conv_state_t;

    // Position of the top bit, and the position after reset.
    localparam logic [3:0] TOP_POS    = 4'(RESULT_W - 1);
    localparam logic [3:0] LAST_POS   = 4'h0;
    // Interval count at which the lowest bit is resolved.
    localparam logic [3:0] DONE_COUNT = 4'(FULL_INTERVALS - 1);

    // Phase.
    conv_state_t state_r;
    conv_state_t state_nxt;

    // Approximation register and its bit-by-bit step value.
    result_t     sar_r;
    result_t     sar_nxt;
    result_t     step_value;

    // Trial bit position and interval count.
    logic [3:0]  pos_r;
    logic [3:0]  pos_nxt;
    logic [3:0]  interval_r;
    logic [3:0]  interval_nxt;

    // Completion flag, active low.
    logic        done_n_r;
    logic        done_n_nxt;

    // Decoded conditions shared by two or more groups.
    logic        load_req;
    logic        step_en;
    logic        last_step;

    // True when the position counter selects bit idx.
    function automatic logic pos_is(
        input logic [3:0]  pos,
        input int unsigned idx
    );
        pos_is = (pos == 4'(idx));
    endfunction

    // A held request wins over stepping, so a restart never mixes with an old run.
    assign load_req  = !pins.convert_request_n;                          // [R3]
    assign step_en   = !load_req
                    && ((state_r == ST_LOAD) || (state_r == ST_RUN));
    assign last_step = pos_is(pos_r, 0);

    // One slice per bit: the trial bit takes the comparator, the next lower bit is cleared.
    for (genvar i = 0; i < RESULT_W; i++) begin : g_bit
        if (i == RESULT_W - 1) begin : g_top
            assign step_value[i] = pos_is(pos_r, i) ? comparator_bit : sar_r[i]; // [R13]
        end else begin : g_low
            assign step_value[i] = pos_is(pos_r, i) ? comparator_bit    // [R13]
                                 : pos_is(pos_r, i + 1) ? 1'b0       // [R10]
                                 : sar_r[i];
        end
    end

    // Phase: any request reloads, the last resolved bit ends the run.
    always_comb begin
        state_nxt = state_r;
        if (load_req) begin
            state_nxt = ST_LOAD;
        end else begin
            // Idle and done hold; load and run step until the lowest bit.
            unique case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                ST_LOAD: begin
                    state_nxt = last_step ? ST_DONE : ST_RUN;
                end
                ST_RUN: begin
                    state_nxt = last_step ? ST_DONE : ST_RUN;
                end
                ST_DONE: begin
                    state_nxt = ST_DONE;                                 // [R11]
                end
            endcase
        end
    end

    // Reset leaves no conversion running.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Position: points at the trial bit and walks down one bit per edge.
    // It stops at the lowest bit so the finished result is never disturbed.
    always_comb begin
        pos_nxt = pos_r;
        if (load_req) begin
            pos_nxt = TOP_POS;
        end else if (step_en && !last_step) begin
            pos_nxt = pos_r - 4'h1;                                      // [R10]
        end
    end

    // Position register.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_r <= LAST_POS;
        end else begin
            pos_r <= pos_nxt;
        end
    end

    // Interval counter: the load edge is the first interval of a conversion.
    // It stops one above the done count because no stepping happens after that.
    always_comb begin
        interval_nxt = interval_r;
        if (load_req) begin
            interval_nxt = 4'h1;
        end else if (step_en) begin
            interval_nxt = interval_r + 4'h1;                            // [R12]
        end
    end

    // Interval register.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            interval_r <= 4'h0;
        end else begin
            interval_r <= interval_nxt;
        end
    end

    // Register: load pattern on request, one resolved bit per step, then hold.
    always_comb begin
        sar_nxt = sar_r;                                                 // [R11]
        if (load_req) begin
            sar_nxt = SAR_RESET_VALUE;                                   // [R3] [R9]
        end else if (step_en) begin
            sar_nxt = step_value;                                        // [R10]
        end
    end

    // Approximation register.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sar_r <= SAR_IDLE_VALUE;
        end else begin
            sar_r <= sar_nxt;
        end
    end

    // Completion: high from the load until the lowest bit has been resolved.
    always_comb begin
        done_n_nxt = done_n_r;                                           // [R11]
        if (load_req) begin
            done_n_nxt = 1'b1;                                           // [R4]
        end else if (step_en && (interval_r == DONE_COUNT)) begin
            done_n_nxt = 1'b0;                                           // [R4] [R12]
        end
    end

    // Completion register.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_n_r <= 1'b1;
        end else begin
            done_n_r <= done_n_nxt;
        end
    end

    // Every output below comes straight from a flip-flop.
    assign pins.result_lines = sar_r;                                    // [R1] [R8]
    assign pins.done_flag_n  = done_n_r;                                 // [R2]
    assign trial_index       = pos_r;
endmodule // sar_adc_conversion_control

// [design/sar_adc_pkg.sv]
// Package: shared constants for the successive-approximation converter control and its controller.
// Assumes a single 50 MHz clock shared by both ends.
package sar_adc_pkg;
    localparam int unsigned  RESULT_W        = 12;
    localparam int unsigned  CODE_COUNT      = 4096;
    localparam int unsigned  FULL_INTERVALS  = 13;
    localparam int unsigned  SHORT_INTERVALS = 11;
    localparam int unsigned  SAVED_INTERVALS = 2;
    localparam int unsigned  BIT_TWO_POS     = 2;
    localparam logic [11:0]  SAR_RESET_VALUE = 12'h7FF;
    localparam logic [11:0]  SAR_IDLE_VALUE  = 12'hFFF;
    localparam real          CLK_PERIOD_NS   = 20.0;
    typedef logic [RESULT_W-1:0] result_t;
endpackage

// [design/sar_adc_if.sv]
// Interface: pins between the converter control and the controller that drives it.
// Assumes both modports share core_clk.
`timescale 1ns/100ps
interface sar_adc_if;
    logic                      convert_request_n;
    logic                      done_flag_n;
    sar_adc_pkg::result_t      result_lines;
    modport converter (input convert_request_n, output done_flag_n, output result_lines);
    modport controller (output convert_request_n, input done_flag_n, input result_lines);
endinterface

// [design/sar_adc_controller.sv]
// Controller end: drives the start request and captures results.
// Assumes the converter end on the same core_clk.
`timescale 1ns/100ps
module sar_adc_controller (
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          start,
    input  wire logic          continuous,
    input  wire logic          short_cycle,
    output sar_adc_pkg::result_t value,
    output logic               value_valid,
    sar_adc_if.controller      pins
);
    import sar_adc_pkg::*;

    logic    req_n_r;
    logic    req_n_nxt;
    logic    done_d_r;
    result_t value_r;
    result_t value_nxt;
    logic    valid_r;
    logic    valid_nxt;
    logic    finish;

    // Short cycle: bit two low or completion low ends the sequence, so it never locks up.
    assign finish = short_cycle
        ? !(pins.result_lines[BIT_TWO_POS] & pins.done_flag_n) // [R5] [R6]
        : !pins.done_flag_n;

    always_comb begin
        req_n_nxt = 1'b1;
        value_nxt = value_r;
        valid_nxt = 1'b0;
        if (finish && done_d_r) begin
            value_nxt = ~pins.result_lines;              // [R1] [R2]
            valid_nxt = 1'b1;
        end
        if (start || (continuous && finish)) begin
            req_n_nxt = 1'b0;                             // [R7]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_n_r  <= 1'b1;
            done_d_r <= 1'b0;
            value_r  <= '0;
            valid_r  <= 1'b0;
        end else begin
            req_n_r  <= req_n_nxt;
            done_d_r <= !finish;
            value_r  <= value_nxt;
            valid_r  <= valid_nxt;
        end
    end

    assign pins.convert_request_n = req_n_r;
    assign value       = value_r;
    assign value_valid = valid_r;
endmodule // sar_adc_controller

// [tb/sar_adc_properties.sv]
// Checker: pin timing of the converter end.
// Assumes it is instantiated beside the interface.
`timescale 1ns/100ps
module sar_adc_properties (
    input wire logic                 core_clk,
    input wire logic                 rst_b,
    input wire logic                 convert_request_n,
    input wire logic                 done_flag_n,
    input wire sar_adc_pkg::result_t result_lines
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    load_a: assert property (!convert_request_n |=> result_lines == 12'h7FF)
        else $error("load");
    busy_a: assert property (!convert_request_n |=> done_flag_n)
        else $error("busy");
    run_busy_a: assert property ($rose(convert_request_n) |-> done_flag_n[*8])
        else $error("run busy");
    conv_len_a: assert property ($fell(done_flag_n) |->
        $past(convert_request_n, 12) && !$past(convert_request_n, 13)) else $error("length");
    first_step_a: assert property ($rose(convert_request_n) |=>
        result_lines[10:0] == 11'h3FF) else $error("step one");
    next_step_a: assert property ($rose(convert_request_n) ##1 convert_request_n |=>
        result_lines[9:0] == 10'h1FF) else $error("step two");
    hold_result_a: assert property (!done_flag_n && convert_request_n |=>
        $stable(result_lines)) else $error("result hold");
    hold_done_a: assert property (!done_flag_n && convert_request_n |=> !done_flag_n)
        else $error("done hold");
endmodule // sar_adc_properties

// [tb/sar_adc_conversion_control_bench.sv]
// Bench: both ends joined by the interface, comparator driven from a target pattern.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/100ps
module sar_adc_conversion_control_bench;
    import sar_adc_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       start = 1'b0;
    logic       continuous = 1'b0;
    logic       short_cycle = 1'b0;
    logic [3:0] trial_index;
    logic       value_valid;
    result_t    pat = 12'h000;
    result_t    value;
    result_t    codes [4] = '{12'h000, 12'hFFF, 12'h555, 12'hA3C};
    int         fail_count = 0;
    int         checks = 0;
    wire logic  comparator_bit = pat[trial_index];
    sar_adc_if sar_adc_if_i ();
    sar_adc_conversion_control sar_adc_conversion_control_i (.core_clk(core_clk), .rst_b(rst_b),
        .comparator_bit(comparator_bit), .trial_index(trial_index), .pins(sar_adc_if_i));
    sar_adc_controller sar_adc_controller_i (.core_clk(core_clk), .rst_b(rst_b), .start(start),
        .continuous(continuous), .short_cycle(short_cycle), .value(value),
        .value_valid(value_valid), .pins(sar_adc_if_i));
    sar_adc_properties sar_adc_properties_i (.core_clk(core_clk), .rst_b(rst_b),
        .convert_request_n(sar_adc_if_i.convert_request_n),
        .done_flag_n(sar_adc_if_i.done_flag_n), .result_lines(sar_adc_if_i.result_lines));
    always #10 core_clk = ~core_clk;
    task automatic cmp(input string what, input result_t exp, input result_t got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic await_value(input result_t code, input result_t mask);
        int n;
        for (n = 0; n < 40 && value_valid !== 1'b1; n++) @(posedge core_clk) #1;
        if (n == 40) begin
            fail_count++;
            end_sim();
        end
        cmp("value", ~code & mask, value & mask);
        cmp("result", code & mask, sar_adc_if_i.result_lines & mask);
        $display("conversion %h done", code);
        @(posedge core_clk);
    endtask
    task automatic convert(input result_t code, input result_t mask);
        pat <= code;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        await_value(code, mask);
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (codes[i]) convert(codes[i], 12'hFFF);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (5) @(posedge core_clk);
        convert(12'h9C3, 12'hFFF);
        short_cycle <= 1'b1;
        convert(12'h6B5, 12'hFF8);
        repeat (16) @(posedge core_clk);
        short_cycle <= 1'b0;
        continuous <= 1'b1;
        convert(12'h3E1, 12'hFFF);
        await_value(12'h3E1, 12'hFFF);
        end_sim();
    end
endmodule // sar_adc_conversion_control_bench
